/* File: design/seid_consts.svh */
// Purpose: Constants of the serial error, flag, interrupt and request logic
// Assumes: Included by the package and the design modules
// Notes:   Flag positions are shared by status, mask and clear vectors
`ifndef SEID_CONSTS_SVH
`define SEID_CONSTS_SVH

`define SEID_FRAME_W     8
`define SEID_FLAG_N      8
`define SEID_BITCNT_W    3
`define SEID_BITCNT_LAST 3'h7
`define SEID_BITCNT_ZERO 3'h0

`define SEID_F_TXE       0
`define SEID_F_RX_FULL_FLAG      1
`define SEID_F_FALL      2
`define SEID_F_RISE      3
`define SEID_F_STARVE    4
`define SEID_F_LOST      5
`define SEID_F_ABORT     6
`define SEID_F_MMF       7

`define SEID_FLAGS_RST   8'h01
`define SEID_NONE_CLR    8'h00
`define SEID_CS_IDLE     1'h1
`define SEID_BYTE_RST    8'h00

`endif

/* File: design/seid_core.sv */
// Purpose: Error flags, status flags, shared interrupt and request lines
// Assumes: Slave frames come from seid_link on the serial clock
// Notes:   Software strobes are one-cycle pulses on the system clock
//
// Function
// - Slave: select rising during a frame sets the select abort flag.
// - Select abort drops the current frame and leaves the slave unselected.
// - Select low again resumes transfers; abort flag stays until cleared.
// - Frame done while receive-full still set sets the lost frame flag.
// - On overrun the new frame replaces the old receive data.
// - Transfers continue after overrun; lost flag stays until cleared.
// - Slave frame starting with empty transmit buffer sets the starved flag.
// - Transfers continue after underflow; starved flag stays until cleared.
// - Eight flags, set by hardware; each requests only while enabled.
// - All enabled sources merge onto one interrupt line.
// - Receive-full clears on data read or written 0; empty clears on write.
// - Edge, starved, lost, abort and fault flags clear by writing 0.
// - Transmit request while transmit enable set and buffer empty.
// - Receive request while receive enable set and buffer full.
// - Transmit and receive requests use separate, independent lines.
// - Transmit-empty sets when data moves into the shifter.
// - Receive-full sets when a frame moves into the data register.
// - Master with select as input and select low: fault, enable cleared.
`timescale 1ns/1ps
`include "seid_consts.svh"

module seid_core
(
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  sck,
  input  wire logic                  cs_n,
  input  wire logic                  mosi,
  output logic                       miso,
  input  wire logic                  master_mode,
  input  wire logic                  cs_input_mode,
  input  wire logic                  ctrl_enable_wr,
  input  wire logic                  ctrl_enable_wdata,
  output logic                       ctrl_enable,
  input  wire logic                  data_register_wr,
  input  wire seid_pkg::seid_word_t  data_register_wdata,
  input  wire logic                  data_register_rd,
  output seid_pkg::seid_word_t       data_register,
  input  wire logic                  flag_clear_wr,
  input  wire seid_pkg::seid_flags_t flag_clear_register,
  input  wire seid_pkg::seid_flags_t interrupt_enable_mask,
  output seid_pkg::seid_flags_t      flag_status_register,
  output logic                       irq,
  input  wire logic                  dma_tx_request_enable,
  input  wire logic                  dma_rx_request_enable,
  output logic                       dma_tx_req,
  output logic                       dma_rx_req,
  output logic                       busy
);

  seid_pkg::seid_core_s  q_r;
  seid_pkg::seid_core_s  q_nxt;
  seid_link_if           lnk ();
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  st_edge;
  logic                  dn_edge;
  logic                  abort_ev;
  logic                  starve_ev;
  logic                  lost_ev;
  logic                  mmf_ev;
  logic                  commit;
  logic                  wr_take;
  seid_pkg::seid_flags_t set_v;
  seid_pkg::seid_flags_t clr_v;

  function automatic logic rose(input logic now_v, input logic old_v);
    rose = now_v & ~old_v;
  endfunction

  seid_link u_link
  (
    .sck     (sck),
    .sys_rst (sys_rst),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .lnk     (lnk.link)
  );

  assign cs_fall   = rose(q_r.cs_s3, q_r.cs_s2);
  assign cs_rise   = rose(q_r.cs_s2, q_r.cs_s3);
  assign st_edge   = rose(q_r.st_s2, q_r.st_s3);
  assign dn_edge   = rose(q_r.dn_s2, q_r.dn_s3);
  assign abort_ev  = ~master_mode & cs_rise & q_r.in_frame;
  assign starve_ev = ~master_mode & st_edge & ~q_r.tx_valid;
  assign lost_ev   = dn_edge & q_r.flags[`SEID_F_RX_FULL_FLAG];
  assign mmf_ev    = master_mode & cs_input_mode & q_r.ctrl_en & ~q_r.cs_s2;
  // Hand the next word to the shifter at selection and after each frame
  assign commit    = cs_fall | dn_edge;
  // A write while a word still waits would overwrite tx_shadow before that word reaches the shifter
  assign wr_take   = data_register_wr & ~q_r.pending;

  always_comb
  begin
    set_v                = `SEID_NONE_CLR;
    set_v[`SEID_F_TXE]   = commit & q_r.pending;
    set_v[`SEID_F_RX_FULL_FLAG]  = dn_edge;
    set_v[`SEID_F_FALL]  = cs_fall;
    set_v[`SEID_F_RISE]  = cs_rise;
    set_v[`SEID_F_STARVE] = starve_ev;
    set_v[`SEID_F_LOST]  = lost_ev;
    set_v[`SEID_F_ABORT] = abort_ev;
    set_v[`SEID_F_MMF]   = mmf_ev;
    // Written zeros clear, written ones keep; transmit-empty only by a data write
    clr_v = flag_clear_wr ? ~flag_clear_register : `SEID_NONE_CLR;
    clr_v[`SEID_F_TXE]  = wr_take;
    clr_v[`SEID_F_RX_FULL_FLAG] = clr_v[`SEID_F_RX_FULL_FLAG] | data_register_rd;
  end

  always_comb
  begin
    q_nxt       = q_r;
    q_nxt.cs_s1 = cs_n;
    q_nxt.cs_s2 = q_r.cs_s1;
    q_nxt.cs_s3 = q_r.cs_s2;
    q_nxt.st_s1 = lnk.start_l;
    q_nxt.st_s2 = q_r.st_s1;
    q_nxt.st_s3 = q_r.st_s2;
    q_nxt.dn_s1 = lnk.done_l;
    q_nxt.dn_s2 = q_r.dn_s1;
    q_nxt.dn_s3 = q_r.dn_s2;
    // Flags are sticky; the set term is applied last so it wins
    q_nxt.flags = (q_r.flags & ~clr_v) | set_v;
    if (dn_edge)
    begin
      q_nxt.rx_data = lnk.rx_word;
    end
    if (commit)
    begin
      q_nxt.tx_word  = q_r.tx_shadow;
      q_nxt.tx_valid = q_r.pending;
      q_nxt.pending  = 1'h0;
    end
    // A write meeting an empty hand-over is kept, else transmit-empty would stick low
    if (wr_take)
    begin
      q_nxt.tx_shadow = data_register_wdata;
      q_nxt.pending   = 1'h1;
    end
    if (st_edge)
    begin
      q_nxt.in_frame = 1'h1;
    end
    else if (dn_edge | abort_ev)
    begin
      q_nxt.in_frame = 1'h0;
    end
    if (mmf_ev)
    begin
      q_nxt.ctrl_en = 1'h0;
    end
    else if (ctrl_enable_wr)
    begin
      q_nxt.ctrl_en = ctrl_enable_wdata;
    end
    q_nxt.irq    = |(q_nxt.flags & interrupt_enable_mask);
    q_nxt.dma_tx = dma_tx_request_enable & q_nxt.flags[`SEID_F_TXE];
    q_nxt.dma_rx = dma_rx_request_enable & q_nxt.flags[`SEID_F_RX_FULL_FLAG];
    q_nxt.busy   = q_nxt.pending | q_nxt.in_frame;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q_r          <= '0;
      q_r.cs_s1    <= `SEID_CS_IDLE;
      q_r.cs_s2    <= `SEID_CS_IDLE;
      q_r.cs_s3    <= `SEID_CS_IDLE;
      q_r.flags    <= `SEID_FLAGS_RST;
      q_r.rx_data  <= `SEID_BYTE_RST;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign lnk.tx_word          = q_r.tx_word;
  assign lnk.tx_valid         = q_r.tx_valid;
  assign ctrl_enable          = q_r.ctrl_en;
  assign data_register        = q_r.rx_data;
  assign flag_status_register = q_r.flags;
  assign irq                  = q_r.irq;
  assign dma_tx_req           = q_r.dma_tx;
  assign dma_rx_req           = q_r.dma_rx;
  assign busy                 = q_r.busy;

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (sys_rst);

  sequence s_abort_cause;
    ~master_mode && cs_rise && q_r.in_frame;
  endsequence

  sequence s_abort_kept;
    !(flag_clear_wr && !flag_clear_register[`SEID_F_ABORT]);
  endsequence

  sequence s_lost_cause;
    dn_edge && q_r.flags[`SEID_F_RX_FULL_FLAG];
  endsequence

  property p_abort_set;
    s_abort_cause |=> flag_status_register[`SEID_F_ABORT];
  endproperty
  a_abort_set : assert property (p_abort_set) else $error("abort flag not set");

  property p_abort_unselect;
    s_abort_cause |=> !q_r.in_frame && busy == q_r.pending;
  endproperty
  a_abort_unselect : assert property (p_abort_unselect) else $error("frame kept after abort");

  property p_abort_sticky;
    flag_status_register[`SEID_F_ABORT] and s_abort_kept |=> flag_status_register[`SEID_F_ABORT];
  endproperty
  a_abort_sticky : assert property (p_abort_sticky) else $error("abort flag dropped");

  property p_lost_set;
    s_lost_cause |=> flag_status_register[`SEID_F_LOST] && flag_status_register[`SEID_F_RX_FULL_FLAG];
  endproperty
  a_lost_set : assert property (p_lost_set) else $error("lost flag not set");

  property p_lost_replace;
    s_lost_cause |=> data_register == $past(lnk.rx_word);
  endproperty
  a_lost_replace : assert property (p_lost_replace) else $error("old data kept on overrun");

  property p_lost_sticky;
    flag_status_register[`SEID_F_LOST] && !flag_clear_wr |=> flag_status_register[`SEID_F_LOST];
  endproperty
  a_lost_sticky : assert property (p_lost_sticky) else $error("lost flag dropped");

  property p_starve_set;
    ~master_mode && st_edge && !q_r.tx_valid |=> flag_status_register[`SEID_F_STARVE];
  endproperty
  a_starve_set : assert property (p_starve_set) else $error("starved flag not set");

  property p_irq_merge;
    ##1 irq == |(flag_status_register & $past(interrupt_enable_mask));
  endproperty
  a_irq_merge : assert property (p_irq_merge) else $error("interrupt line mismatch");

  property p_rx_read_clear;
    data_register_rd && !dn_edge |=> !flag_status_register[`SEID_F_RX_FULL_FLAG];
  endproperty
  a_rx_read_clear : assert property (p_rx_read_clear) else $error("read did not clear full");

  property p_zero_clear;
    flag_clear_wr && !flag_clear_register[`SEID_F_FALL] && !cs_fall
      |=> !flag_status_register[`SEID_F_FALL];
  endproperty
  a_zero_clear : assert property (p_zero_clear) else $error("written zero did not clear");

  property p_dma_tx;
    dma_tx_request_enable && flag_status_register[`SEID_F_TXE] && !data_register_wr
      |=> dma_tx_req;
  endproperty
  a_dma_tx : assert property (p_dma_tx) else $error("transmit request missing");

  property p_dma_rx;
    dma_rx_req == ($past(dma_rx_request_enable) && flag_status_register[`SEID_F_RX_FULL_FLAG]);
  endproperty
  a_dma_rx : assert property (p_dma_rx) else $error("receive request without cause");

  property p_tx_empty_set;
    commit && q_r.pending |=> flag_status_register[`SEID_F_TXE] && !q_r.pending;
  endproperty
  a_tx_empty_set : assert property (p_tx_empty_set) else $error("empty flag not set on move");

  property p_rx_full_set;
    dn_edge |=> flag_status_register[`SEID_F_RX_FULL_FLAG] && data_register == $past(lnk.rx_word);
  endproperty
  a_rx_full_set : assert property (p_rx_full_set) else $error("full flag not set on move");

  property p_mode_fault;
    master_mode && cs_input_mode && ctrl_enable && !q_r.cs_s2
      |=> flag_status_register[`SEID_F_MMF] && !ctrl_enable;
  endproperty
  a_mode_fault : assert property (p_mode_fault) else $error("mode fault not taken");

endmodule // seid_core

/* File: design/seid_link.sv */
// Purpose: Slave shifter on the serial clock, one frame of eight bits
// Assumes: Input sampled and output changed on the rising serial edge
// Notes:   A high select resets the frame state, which drops a partial frame
`timescale 1ns/1ps
`include "seid_consts.svh"

module seid_link
(
  input  wire logic sck,
  input  wire logic sys_rst,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso,
  seid_link_if.link lnk
);

  seid_pkg::seid_link_s q_r;
  seid_pkg::seid_link_s q_nxt;
  logic                 link_rst;

  // The serial clock stops outside frames, so the select level ends the frame
  assign link_rst = sys_rst | cs_n;

  always_comb
  begin
    q_nxt       = q_r;
    q_nxt.start = (q_r.bit_cnt == `SEID_BITCNT_ZERO);
    q_nxt.done  = (q_r.bit_cnt == `SEID_BITCNT_LAST);
    q_nxt.sh_rx = {q_r.sh_rx[`SEID_FRAME_W-2:0], mosi};
    q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
    if (q_r.bit_cnt == `SEID_BITCNT_ZERO)
    begin
      q_nxt.miso  = lnk.tx_word[`SEID_FRAME_W-1];
      q_nxt.sh_tx = {lnk.tx_word[`SEID_FRAME_W-2:0], 1'h0};
    end
    else
    begin
      q_nxt.miso  = q_r.sh_tx[`SEID_FRAME_W-1];
      q_nxt.sh_tx = {q_r.sh_tx[`SEID_FRAME_W-2:0], 1'h0};
    end
    if (q_r.bit_cnt == `SEID_BITCNT_LAST)
    begin
      q_nxt.rx_word = {q_r.sh_rx[`SEID_FRAME_W-2:0], mosi};
    end
  end

  always_ff @(posedge sck or posedge link_rst)
  begin
    if (link_rst)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign miso        = q_r.miso;
  assign lnk.start_l = q_r.start;
  assign lnk.done_l  = q_r.done;
  assign lnk.rx_word = q_r.rx_word;

endmodule // seid_link

/* File: design/seid_link_if.sv */
// Purpose: Carrier between the system-clock core and the serial-clock shifter
// Assumes: tx_word and tx_valid change only while no serial edge is due
// Notes:   start_l and done_l are levels held until the next rising serial edge or a high select
`timescale 1ns/1ps
interface seid_link_if;
  seid_pkg::seid_word_t tx_word;
  logic                 tx_valid;
  logic                 start_l;
  logic                 done_l;
  seid_pkg::seid_word_t rx_word;

  modport core
  (
    output tx_word,
    output tx_valid,
    input  start_l,
    input  done_l,
    input  rx_word
  );

  modport link
  (
    input  tx_word,
    input  tx_valid,
    output start_l,
    output done_l,
    output rx_word
  );
endinterface // seid_link_if

/* File: design/seid_pkg.sv */
// Purpose: Types of the serial error, flag, interrupt and request logic
// Assumes: Constants come from seid_consts.svh
// Notes:   One packed struct holds all state of each module
`include "seid_consts.svh"

package seid_pkg;

  typedef logic [`SEID_FRAME_W-1:0] seid_word_t;
  typedef logic [`SEID_FLAG_N-1:0]  seid_flags_t;

  typedef struct packed {
    logic [`SEID_BITCNT_W-1:0] bit_cnt;
    seid_word_t                sh_rx;
    seid_word_t                sh_tx;
    seid_word_t                rx_word;
    logic                      start;
    logic                      done;
    logic                      miso;
  } seid_link_s;

  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        cs_s3;
    logic        st_s1;
    logic        st_s2;
    logic        st_s3;
    logic        dn_s1;
    logic        dn_s2;
    logic        dn_s3;
    seid_flags_t flags;
    seid_word_t  rx_data;
    seid_word_t  tx_shadow;
    logic        pending;
    seid_word_t  tx_word;
    logic        tx_valid;
    logic        in_frame;
    logic        ctrl_en;
    logic        irq;
    logic        dma_tx;
    logic        dma_rx;
    logic        busy;
  } seid_core_s;

endpackage

/* File: verif/seid_master_model.sv */
// Purpose: Remote serial master driving select, clock and data
// Assumes: Slave shifts on the rising serial edge, so miso is read on the falling one
// Notes:   The clock stands still low outside frames; period 30 ns
`timescale 1ns/1ps

module seid_master_model
(
  output logic      sck,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial
  begin
    sck  = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end

  // Long hold keeps the select spacing the slave needs around frames
  task automatic sel(input logic v);
    #3;
    cs_n = v;
    #100;
  endtask

  // Sends n bits MSB first; fewer than eight makes a partial frame
  task automatic xfer(input logic [7:0] t, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      mosi = t[i];
      #15 sck = 1'h1;
      #15 r = {r[6:0], miso};
      sck = 1'h0;
    end
    // Released line shows the inverse so a stale bit cannot pass
    mosi = ~mosi;
    #60;
  endtask
endmodule // seid_master_model

/* File: verif/test_seid_core.sv */
// Purpose: Self-checking bench of the serial flag, error and request logic
// Assumes: The master model owns the serial pins on its own clock
// Notes:   The driver queues expected values; a watcher compares them
`timescale 1ns/1ps

module test_seid_core;
  typedef struct {int k; logic [7:0] v;} seid_note_s;

  logic clock, sys_rst, sck, cs_n, mosi, miso, master_mode, cs_input_mode;
  logic ctrl_enable_wr, ctrl_enable_wdata, ctrl_enable, data_register_wr, data_register_rd;
  logic irq, dma_tx_request_enable, dma_rx_request_enable, dma_tx_req, dma_rx_req, busy;
  seid_pkg::seid_word_t  data_register_wdata, data_register;
  seid_pkg::seid_flags_t flag_clear_register, interrupt_enable_mask, flag_status_register;
  logic                  flag_clear_wr;
  seid_note_s            q[$];
  seid_note_s            cur;
  logic [7:0]            b [4];
  logic [7:0]            seen;
  int                    seed;
  int                    error_cnt = 0;
  int                    compares = 0;

  seid_core uut
  (
    .clock(clock), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .master_mode(master_mode), .cs_input_mode(cs_input_mode), .ctrl_enable_wr(ctrl_enable_wr),
    .ctrl_enable_wdata(ctrl_enable_wdata), .ctrl_enable(ctrl_enable),
    .data_register_wr(data_register_wr), .data_register_wdata(data_register_wdata),
    .data_register_rd(data_register_rd), .data_register(data_register), .flag_clear_wr(flag_clear_wr),
    .flag_clear_register(flag_clear_register), .interrupt_enable_mask(interrupt_enable_mask),
    .flag_status_register(flag_status_register), .irq(irq),
    .dma_tx_request_enable(dma_tx_request_enable), .dma_rx_request_enable(dma_rx_request_enable),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .busy(busy)
  );

  seid_master_model m (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic final_report();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp8(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic cmp1(input string s, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %b got %b", s, e, g);
    end
  endtask

  // Software strobe: 0 data write, 1 data read, 2 flag clear, 3 enable write
  task automatic sw(input int s, input logic [7:0] v);
    @(negedge clock);
    data_register_wdata = v;
    flag_clear_register = v;
    ctrl_enable_wdata = v[0];
    data_register_wr = (s == 0);
    data_register_rd = (s == 1);
    flag_clear_wr = (s == 2);
    ctrl_enable_wr = (s == 3);
    @(negedge clock);
    {data_register_wr, data_register_rd, flag_clear_wr, ctrl_enable_wr} = 4'h0;
  endtask

  // Waits past the select synchroniser latency, then hands the note over
  task automatic note(input int k, input logic [7:0] v);
    int n;
    repeat (12) @(posedge clock);
    q.push_back('{k, v});
    n = 0;
    while (q.size() > 0 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    if (q.size() > 0)
    begin
      error_cnt++;
      $display("[ERR] watcher exp empty got %0d notes", q.size());
      final_report();
    end
  endtask

  // Software holds the controller enabled until no word waits and no frame runs
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'h0 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    if (busy !== 1'h0)
    begin
      error_cnt++;
      $display("[ERR] busy exp 0 got %b", busy);
      final_report();
    end
  endtask

  always @(negedge clock)
  begin
    if (q.size() > 0)
    begin
      cur = q.pop_front();
      case (cur.k)
        0: cmp8("flags", cur.v, flag_status_register);
        1: cmp8("data_register", cur.v, data_register);
        2: cmp1("irq", cur.v[0], irq);
        3: cmp1("dma_tx_req", cur.v[0], dma_tx_req);
        4: cmp1("dma_rx_req", cur.v[0], dma_rx_req);
        5: cmp1("ctrl_enable", cur.v[0], ctrl_enable);
        7: cmp1("busy", cur.v[0], busy);
        default: cmp8("link_rx", cur.v, seen);
      endcase
    end
  end

  initial
  begin
    {master_mode, cs_input_mode, ctrl_enable_wr, ctrl_enable_wdata, data_register_wr} = 5'h00;
    {data_register_rd, flag_clear_wr, dma_tx_request_enable, dma_rx_request_enable} = 4'h0;
    data_register_wdata = 8'h00;
    flag_clear_register = 8'hFF;
    interrupt_enable_mask = 8'h00;
    seed = 32'h5DB9;
    for (int i = 0; i < 4; i++)
      b[i] = 8'($random(seed));
    sys_rst = 1'h1;
    repeat (12) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'h0;
    note(0, 8'h01);
    note(1, 8'h00);
    @(negedge clock);
    dma_tx_request_enable = 1'h1;
    dma_rx_request_enable = 1'h1;
    note(3, 8'h01);
    note(4, 8'h00);
    sw(2, 8'h00);
    note(0, 8'h01);
    sw(0, b[0]);
    note(0, 8'h00);
    note(3, 8'h00);
    m.sel(1'h0);
    note(0, 8'h05);
    m.xfer(b[1], 8, seen);
    note(0, 8'h07);
    note(1, b[1]);
    note(4, 8'h01);
    note(6, b[0]);
    m.xfer(b[2], 8, seen);
    note(0, 8'h37);
    note(1, b[2]);
    m.sel(1'h1);
    note(0, 8'h3F);
    // Both buffers flagged: each request follows only its own random enable
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clock);
      {dma_tx_request_enable, dma_rx_request_enable} = 2'($random(seed));
      interrupt_enable_mask = 8'($random(seed));
      note(3, {7'h00, dma_tx_request_enable});
      note(4, {7'h00, dma_rx_request_enable});
      note(2, {7'h00, |(interrupt_enable_mask & 8'h3F)});
    end
    @(negedge clock);
    {dma_tx_request_enable, dma_rx_request_enable} = 2'h3;
    sw(1, 8'h00);
    note(0, 8'h3D);
    note(4, 8'h00);
    sw(2, 8'hFF);
    note(0, 8'h3D);
    sw(2, 8'hCF);
    note(0, 8'h0D);
    sw(2, 8'h00);
    sw(0, b[3]);
    m.sel(1'h0);
    m.xfer(8'h5A, 4, seen);
    m.sel(1'h1);
    note(0, 8'h4D);
    note(1, b[2]);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clock);
      interrupt_enable_mask = 8'h01 << i;
      note(2, (8'h4D >> i) & 8'h01);
    end
    @(negedge clock);
    interrupt_enable_mask = 8'hB2;
    note(2, 8'h00);
    @(negedge clock);
    interrupt_enable_mask = 8'hFF;
    note(2, 8'h01);
    sw(2, 8'h00);
    sw(3, 8'h01);
    sw(0, ~b[0]);
    note(7, 8'h01);
    m.sel(1'h0);
    m.xfer(b[1], 8, seen);
    note(0, 8'h07);
    note(6, ~b[0]);
    wait_idle();
    sw(3, 8'h00);
    note(5, 8'h00);
    note(7, 8'h00);
    m.sel(1'h1);
    sw(2, 8'h00);
    @(negedge clock);
    master_mode = 1'h1;
    cs_input_mode = 1'h1;
    sw(3, 8'h01);
    note(5, 8'h01);
    m.sel(1'h0);
    note(0, 8'h85);
    note(5, 8'h00);
    m.sel(1'h1);
    final_report();
  end
endmodule // test_seid_core
